// >>> sim/mscr_slave_model.sv
// Slave module model on the module bus: takes relayed bytes and answers queries.
// Assumes the relay drives the forward port; the bench reads rx_q, row_q and ans.
`timescale 1ns/1ps

module mscr_slave_model
    import mscr_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_fwd_valid,
    input wire logic [7:0] i_fwd_byte,
    input wire logic i_fwd_last,
    input wire logic [MSCR_ROW_W-1:0] i_fwd_row,
    output logic o_fwd_ready,
    output logic o_ans_valid,
    output logic [7:0] o_ans_byte,
    output logic o_ans_last,
    input wire logic i_ans_ready
);
    logic [7:0] rx_q[$];
    logic [MSCR_ROW_W-1:0] row_q[$];
    logic [7:0] ans[3] = '{8'h2b, 8'h31, 8'h0a};
    int seed = 32'h0000_51a9;
    int idx = 0;
    int dly = 0;
    bit pend = 0;
    logic fwd_rdy = 1'b0;
    logic ans_vld = 1'b0;
    logic [7:0] ans_byt = 8'h00;
    logic ans_lst = 1'b0;

    assign o_fwd_ready = fwd_rdy;
    assign o_ans_valid = ans_vld;
    assign o_ans_byte = ans_byt;
    assign o_ans_last = ans_lst;

    // A real slave stalls now and then, so ready drops on a quarter of the cycles.
    always @(posedge i_ref_clk)
    begin
        fwd_rdy <= ($random(seed) & 3) != 0;
        if (i_fwd_valid && o_fwd_ready)
        begin
            rx_q.push_back(i_fwd_byte);
            row_q.push_back(i_fwd_row);
            pend = i_fwd_last && (i_fwd_byte == 8'h3f);
            dly = $random(seed) & 7;
        end
        if (o_ans_valid && i_ans_ready)
        begin
            idx++;
            ans_vld <= idx < 3;
            ans_byt <= (idx < 3) ? ans[idx % 3] : ~ans[2];
            ans_lst <= idx == 2;
            pend = idx < 3;
        end
        else if (pend && !o_ans_valid)
        begin
            if (dly == 0)
            begin
                idx = 0;
                ans_vld <= 1'b1;
                ans_byt <= ans[0];
            end
            dly--;
        end
    end
endmodule // mscr_slave_model

// >>> sim/test_master_slave_command_relay.sv
// Bench for the command relay: corner and random commands, status bits, slave role.
// Assumes mscr_slave_model on the module bus; the bench plays host and local sink.
`timescale 1ns/1ps

module test_master_slave_command_relay;
    import mscr_pkg::*;
    logic i_ref_clk = 0, i_resetn = 0, i_pattern_slave_mode = 0, i_cmd_valid = 0;
    logic i_cmd_first = 0, i_cmd_last = 0, i_cmd_block_data = 0, i_cmd_via_master = 0;
    logic i_local_ready = 0, i_out_ready = 0, i_slave_srv = 0, i_stb_read = 0;
    logic i_fail_sum = 0, i_ques_sum = 0, i_esb_sum = 0, i_oper_sum = 0;
    logic i_local_mav = 0, i_need_service = 0;
    logic [3:0] i_row_addr = 0;
    logic [4:0] i_col_addr = 0;
    logic [15:0] i_slave_present = 0;
    logic [7:0] i_cmd_byte = 0, o_local_byte, o_mbus_byte, i_rsp_byte, o_out_byte;
    mscr_kind_e i_cmd_kind = KIND_OTHER;
    logic o_cmd_ready, o_local_valid, o_local_last, o_local_reset, o_mbus_valid;
    logic o_mbus_last, i_mbus_ready, i_rsp_valid, i_rsp_last, o_rsp_ready, o_out_valid;
    logic o_out_last, o_srq, o_master_srv, o_cmd_error, o_is_master;
    logic [3:0] o_mbus_row;
    logic [4:0] o_bus_addr;
    logic [7:0] o_status_byte;
    logic [7:0] loc_q[$], out_q[$], pay[$];
    int seed = 32'h51a8, miscompares = 0, n_compared = 0, cyc = 0, n_err = 0, n_rst = 0;
    int n_ll = 0, n_ol = 0;

    mscr_relay dut
    (
        .i_ref_clk, .i_resetn, .i_row_addr, .i_col_addr, .i_slave_present,
        .i_pattern_slave_mode, .i_cmd_valid, .i_cmd_byte, .i_cmd_first, .i_cmd_last,
        .i_cmd_kind, .i_cmd_block_data, .i_cmd_via_master, .o_cmd_ready, .o_local_valid,
        .o_local_byte, .o_local_last, .i_local_ready, .o_local_reset, .o_mbus_valid,
        .o_mbus_byte, .o_mbus_last, .o_mbus_row, .i_mbus_ready, .i_rsp_valid, .i_rsp_byte,
        .i_rsp_last, .o_rsp_ready, .o_out_valid, .o_out_byte, .o_out_last, .i_out_ready,
        .i_slave_srv, .i_stb_read, .i_fail_sum, .i_ques_sum, .i_esb_sum, .i_oper_sum,
        .i_local_mav, .i_need_service, .o_srq, .o_master_srv, .o_status_byte,
        .o_cmd_error, .o_is_master, .o_bus_addr
    );

    mscr_slave_model slv
    (
        .i_ref_clk, .i_fwd_valid(o_mbus_valid), .i_fwd_byte(o_mbus_byte),
        .i_fwd_last(o_mbus_last), .i_fwd_row(o_mbus_row), .o_fwd_ready(i_mbus_ready),
        .o_ans_valid(i_rsp_valid), .o_ans_byte(i_rsp_byte), .o_ans_last(i_rsp_last),
        .i_ans_ready(o_rsp_ready)
    );

    initial
    begin
        forever #2.5 i_ref_clk = ~i_ref_clk;
    end

    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // ****************************************************************
    // Sinks, pulse counters and the hang guard
    // ****************************************************************
    always @(posedge i_ref_clk)
    begin
        cyc++;
        if (o_local_valid && i_local_ready)
            loc_q.push_back(o_local_byte);
        if (o_out_valid && i_out_ready)
            out_q.push_back(o_out_byte);
        n_err += (o_cmd_error === 1'b1);
        n_rst += (o_local_reset === 1'b1);
        n_ll += ((o_local_valid && i_local_ready && o_local_last) === 1'b1);
        n_ol += ((o_out_valid && i_out_ready && o_out_last) === 1'b1);
        i_local_ready <= 1'($random(seed));
        i_out_ready <= 1'($random(seed));
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end

    function automatic logic [3:0] exp_row(input logic [15:0] p);
        for (int r = 1; r < MSCR_ROWS; r++)
            if (p[r])
                return r[3:0];
        return ROW_CLK_SRC;
    endfunction

    task automatic do_reset(input logic [3:0] r, input logic [4:0] c);
        i_resetn <= 0;
        i_row_addr <= r;
        i_col_addr <= c;
        repeat (8) @(posedge i_ref_clk);
        i_resetn <= 1;
        repeat (3) @(posedge i_ref_clk);
        chk(o_is_master, r == ROW_MASTER, "role");
        chk(o_bus_addr, c, "bus address");
        $display("reset done row %0d", r);
    endtask

    task automatic send(input mscr_kind_e k, input logic b, input logic v);
        foreach (pay[i])
        begin
            i_cmd_valid <= 1;
            i_cmd_byte <= pay[i];
            i_cmd_first <= i == 0;
            i_cmd_last <= i == pay.size() - 1;
            i_cmd_kind <= k;
            i_cmd_block_data <= b;
            i_cmd_via_master <= v;
            do @(posedge i_ref_clk); while (o_cmd_ready !== 1'b1);
        end
        i_cmd_valid <= 0;
    endtask

    task automatic run(input mscr_kind_e k, input logic b, input logic v);
        logic ok, fwd, loc;
        int e0, r0, l0, o0;
        e0 = n_err;
        r0 = n_rst;
        l0 = n_ll;
        o0 = n_ol;
        loc_q.delete();
        out_q.delete();
        slv.rx_q.delete();
        slv.row_q.delete();
        send(k, b, v);
        // Mode and presence were just driven by non-blocking assignment; read them only now.
        ok = (i_row_addr == ROW_MASTER) || v;
        fwd = ok && !b && (k == KIND_RELAY || k == KIND_RELAY_QUERY
            || (k == KIND_PATTERN_NODE && i_pattern_slave_mode));
        loc = ok && (k == KIND_OTHER || k == KIND_RESET
            || (k == KIND_PATTERN_NODE && !i_pattern_slave_mode));
        repeat (40) @(posedge i_ref_clk);
        chk(slv.rx_q.size(), fwd ? pay.size() : 0, "forward count");
        foreach (slv.rx_q[i]) chk(slv.rx_q[i], pay[i], "forward byte");
        foreach (slv.row_q[i]) chk(slv.row_q[i], exp_row(i_slave_present), "row");
        chk(loc_q.size(), loc ? pay.size() : 0, "local count");
        chk(n_ll - l0, loc, "local last");
        foreach (loc_q[i]) chk(loc_q[i], pay[i], "local byte");
        chk(out_q.size(), (fwd && k == KIND_RELAY_QUERY) ? 3 : 0, "answer count");
        chk(n_ol - o0, fwd && k == KIND_RELAY_QUERY, "answer last");
        foreach (out_q[i]) chk(out_q[i], slv.ans[i], "answer byte");
        chk(n_err - e0, ok && b, "command error");
        chk(n_rst - r0, ok && k == KIND_RESET, "reset pulse");
        $display("command kind %0d done", k);
    endtask

    initial
    begin
        mscr_kind_e k;
        logic b;
        logic [15:0] pres[3];
        logic [23:0] prv;
        int t;
        pres = '{16'h0006, 16'h0004, 16'h0000};
        do_reset(ROW_MASTER, COL_PAT_GEN);
        for (int i = 0; i < 3; i++)
        begin
            i_slave_present <= pres[i];
            pay = '{8'h27, 8'h2a, 8'h52, 8'h53, 8'h54, 8'h27};
            run(KIND_RELAY, 0, 0);
            // Outer quotes hold an inner quoted relay meant for the slave one level further down.
            pay = '{8'h27, 8'h50, 8'h20, 8'h22, 8'h2a, 8'h52, 8'h22, 8'h27};
            run(KIND_RELAY, 0, 0);
            pay = '{8'h2a, 8'h53, 8'h54, 8'h42, 8'h3f};
            run(KIND_RELAY_QUERY, 0, 1);
        end
        // A host polls a relayed reading until two in a row agree; the model's reading is fixed.
        t = 0;
        do
        begin
            prv = {out_q[0], out_q[1], out_q[2]};
            run(KIND_RELAY_QUERY, 0, 1);
            t++;
        end
        while (prv !== {out_q[0], out_q[1], out_q[2]} && t < 4);
        chk(t, 1, "polls to settle");
        for (int i = 0; i < 60; i++)
        begin
            t = $unsigned($random(seed)) % 5;
            k = mscr_kind_e'(t[2:0]);
            b = (k == KIND_RELAY || k == KIND_RELAY_QUERY) && (($random(seed) & 3) == 0);
            i_slave_present <= 16'($random(seed));
            i_pattern_slave_mode <= 1'($random(seed));
            pay.delete();
            repeat (1 + ($random(seed) & 3)) pay.push_back(8'($random(seed)));
            pay[$] = (k == KIND_RELAY_QUERY) ? 8'h3f : pay[$] & 8'h7e;
            run(k, b, 1'($random(seed)));
        end
        i_slave_srv <= 1;
        repeat (3) @(posedge i_ref_clk);
        chk(o_status_byte, 8'h42, "slave service");
        chk(o_srq, 1, "service request");
        i_slave_srv <= 0;
        i_stb_read <= 1;
        @(posedge i_ref_clk);
        i_stb_read <= 0;
        repeat (3) @(posedge i_ref_clk);
        chk(o_status_byte, STB_RESET, "cleared");
        for (int i = 0; i < 5; i++)
        begin
            {i_oper_sum, i_esb_sum, i_local_mav, i_ques_sum, i_fail_sum} <= 5'h01 << i;
            repeat (3) @(posedge i_ref_clk);
            t = (i == 0) ? STB_FAIL : (i == 1) ? STB_QUES : (i == 2) ? STB_MAV
                : (i == 3) ? STB_ESB : STB_OPER;
            chk(o_status_byte, 16'h0040 | (16'h0001 << t), "summary bits");
        end
        {i_oper_sum, i_esb_sum, i_local_mav, i_ques_sum, i_fail_sum} <= 5'h00;
        $display("master status done");
        do_reset(ROW_CLK_SRC, COL_CLK_SRC);
        pay = '{8'h2a, 8'h43, 8'h4c, 8'h53};
        run(KIND_OTHER, 0, 0);
        run(KIND_OTHER, 0, 1);
        i_need_service <= 1;
        repeat (3) @(posedge i_ref_clk);
        chk(o_srq, 0, "slave srq");
        chk(o_master_srv, 1, "slave to master");
        i_need_service <= 0;
        i_local_mav <= 1;
        repeat (3) @(posedge i_ref_clk);
        chk(o_status_byte[STB_MAV], 0, "slave mav");
        chk(o_master_srv, 1, "mav as request");
        chk(o_srq, 0, "slave srq");
        $display("slave role done");
        results();
    end
endmodule // test_master_slave_command_relay

// >>> src/mscr_pkg.sv
// Package for the master/slave command relay: kinds, states, status bits, addresses.
// Assumes an upstream parser that classifies each host command and marks its first byte.
package mscr_pkg;

    // ****************************************************************
    // Field widths and status byte layout
    // ****************************************************************
    localparam int MSCR_ROW_W = 4;
    localparam int MSCR_COL_W = 5;
    localparam int MSCR_ROWS = 16;
    localparam int STB_FAIL = 0;
    localparam int STB_SLAVE = 1;
    localparam int STB_QUES = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_RQS = 6;
    localparam int STB_OPER = 7;
    localparam logic [7:0] STB_RESET = 8'h00;
    localparam logic [MSCR_ROW_W-1:0] ROW_MASTER = 4'h0;
    localparam logic [MSCR_ROW_W-1:0] ROW_NONE = 4'h0;

    // ****************************************************************
    // Recommended remote setup: two masters and one slave
    // ****************************************************************
    localparam logic [MSCR_COL_W-1:0] COL_ERR_DET = 5'h11;
    localparam logic [MSCR_COL_W-1:0] COL_PAT_GEN = 5'h12;
    localparam logic [MSCR_COL_W-1:0] COL_CLK_SRC = 5'h13;
    localparam logic [MSCR_ROW_W-1:0] ROW_CLK_SRC = 4'h2;

    typedef enum logic [2:0]
    {
        KIND_OTHER = 3'h0,
        KIND_RELAY = 3'h1,
        KIND_RELAY_QUERY = 3'h2,
        KIND_PATTERN_NODE = 3'h3,
        KIND_RESET = 3'h4
    } mscr_kind_e;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'b0_0001,
        ST_LOCAL = 5'b0_0010,
        ST_FWD = 5'b0_0100,
        ST_DROP = 5'b0_1000,
        ST_RSP = 5'b1_0000
    } mscr_state_e;

endpackage

// >>> src/mscr_relay.sv
// Command relay between a master module and the slaves behind it on the module bus.
// Assumes commands arrive as bytes, kind and block-data flag valid on the first byte.
`timescale 1ns/1ps

module mscr_relay
    import mscr_pkg::*;
#(
    parameter logic [MSCR_ROW_W-1:0] P_DEFAULT_SLAVE_ROW = ROW_CLK_SRC
)
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic [MSCR_ROW_W-1:0] i_row_addr,
    input wire logic [MSCR_COL_W-1:0] i_col_addr,
    input wire logic [MSCR_ROWS-1:0] i_slave_present,
    input wire logic i_pattern_slave_mode,
    input wire logic i_cmd_valid,
    input wire logic [7:0] i_cmd_byte,
    input wire logic i_cmd_first,
    input wire logic i_cmd_last,
    input wire mscr_kind_e i_cmd_kind,
    input wire logic i_cmd_block_data,
    input wire logic i_cmd_via_master,
    output logic o_cmd_ready,
    output logic o_local_valid,
    output logic [7:0] o_local_byte,
    output logic o_local_last,
    input wire logic i_local_ready,
    output logic o_local_reset,
    output logic o_mbus_valid,
    output logic [7:0] o_mbus_byte,
    output logic o_mbus_last,
    output logic [MSCR_ROW_W-1:0] o_mbus_row,
    input wire logic i_mbus_ready,
    input wire logic i_rsp_valid,
    input wire logic [7:0] i_rsp_byte,
    input wire logic i_rsp_last,
    output logic o_rsp_ready,
    output logic o_out_valid,
    output logic [7:0] o_out_byte,
    output logic o_out_last,
    input wire logic i_out_ready,
    input wire logic i_slave_srv,
    input wire logic i_stb_read,
    input wire logic i_fail_sum,
    input wire logic i_ques_sum,
    input wire logic i_esb_sum,
    input wire logic i_oper_sum,
    input wire logic i_local_mav,
    input wire logic i_need_service,
    output logic o_srq,
    output logic o_master_srv,
    output logic [7:0] o_status_byte,
    output logic o_cmd_error,
    output logic o_is_master,
    output logic [MSCR_COL_W-1:0] o_bus_addr
);

    // ****************************************************************
    // State record
    // ****************************************************************
    typedef struct packed
    {
        mscr_state_e state;
        logic straps_taken;
        logic is_master;
        logic [MSCR_ROW_W-1:0] own_row;
        logic [MSCR_COL_W-1:0] bus_addr;
        logic [MSCR_ROW_W-1:0] fwd_row;
        logic query;
        logic local_valid;
        logic [7:0] local_byte;
        logic local_last;
        logic local_reset;
        logic mbus_valid;
        logic [7:0] mbus_byte;
        logic mbus_last;
        logic out_valid;
        logic [7:0] out_byte;
        logic out_last;
        logic slave_flag;
        logic [7:0] stb;
        logic srq;
        logic master_srv;
        logic cmd_error;
    } mscr_state_s;

    mscr_state_s s_q;
    mscr_state_s s_d;
    logic [MSCR_ROW_W-1:0] next_row;
    logic take_cmd;
    logic take_rsp;
    logic local_free;
    logic mbus_free;
    logic out_free;
    logic accept_ok;

    assign local_free = !s_q.local_valid || i_local_ready;
    assign mbus_free = !s_q.mbus_valid || i_mbus_ready;
    assign out_free = !s_q.out_valid || i_out_ready;
    // A slave only listens to what its master hands down.
    assign accept_ok = s_q.is_master || i_cmd_via_master;

    // Nearest present row above our own; scanning down leaves the lowest match.
    always_comb
    begin
        next_row = P_DEFAULT_SLAVE_ROW;
        for (int r = MSCR_ROWS - 1; r >= 0; r--)
        begin
            if (i_slave_present[r] && (r > int'(s_q.own_row)))
            begin
                next_row = MSCR_ROW_W'(r);
            end
        end
    end

    always_comb
    begin
        case (s_q.state)
            // The last byte of the previous frame may still sit in a stage; wait for it to drain.
            ST_IDLE: o_cmd_ready = s_q.straps_taken && !s_q.local_reset
                && local_free && mbus_free;
            ST_LOCAL: o_cmd_ready = local_free;
            ST_FWD: o_cmd_ready = mbus_free;
            ST_DROP: o_cmd_ready = 1'b1;
            default: o_cmd_ready = 1'b0;
        endcase
    end

    assign take_cmd = i_cmd_valid && o_cmd_ready;
    assign o_rsp_ready = (s_q.state == ST_RSP) && out_free;
    assign take_rsp = i_rsp_valid && o_rsp_ready;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        mscr_state_e dest;
        logic [7:0] stb_n;
        dest = ST_IDLE;
        stb_n = STB_RESET;
        s_d = s_q;
        s_d.local_reset = 1'b0;
        s_d.cmd_error = 1'b0;
        if (i_local_ready)
        begin
            s_d.local_valid = 1'b0;
        end
        if (i_mbus_ready)
        begin
            s_d.mbus_valid = 1'b0;
        end
        if (i_out_ready)
        begin
            s_d.out_valid = 1'b0;
        end
        // Straps are sampled once, on the first edge after reset release.
        if (!s_q.straps_taken)
        begin
            s_d.straps_taken = 1'b1;
            s_d.own_row = i_row_addr;
            s_d.is_master = (i_row_addr == ROW_MASTER);
            s_d.bus_addr = i_col_addr;
        end
        case (s_q.state)
            ST_IDLE:
            begin
                if (take_cmd && i_cmd_first && accept_ok)
                begin
                    if (i_cmd_kind == KIND_RELAY || i_cmd_kind == KIND_RELAY_QUERY)
                    begin
                        if (i_cmd_block_data)
                        begin
                            s_d.cmd_error = 1'b1;
                            dest = ST_DROP;
                        end
                        else
                        begin
                            dest = ST_FWD;
                        end
                    end
                    else if (i_cmd_kind == KIND_PATTERN_NODE && i_pattern_slave_mode)
                    begin
                        dest = ST_FWD;
                    end
                    else
                    begin
                        dest = ST_LOCAL;
                        // Only the addressed module resets; slaves need a relayed reset.
                        s_d.local_reset = (i_cmd_kind == KIND_RESET);
                    end
                    s_d.query = (i_cmd_kind == KIND_RELAY_QUERY) && !i_cmd_block_data;
                    s_d.fwd_row = next_row;
                end
                else if (take_cmd)
                begin
                    dest = ST_DROP;
                end
            end
            default:
            begin
                dest = s_q.state;
            end
        endcase
        if (take_cmd)
        begin
            case (dest)
                ST_LOCAL:
                begin
                    s_d.local_valid = 1'b1;
                    s_d.local_byte = i_cmd_byte;
                    s_d.local_last = i_cmd_last;
                end
                ST_FWD:
                begin
                    s_d.mbus_valid = 1'b1;
                    s_d.mbus_byte = i_cmd_byte;
                    s_d.mbus_last = i_cmd_last;
                end
                default:
                begin
                end
            endcase
            if (i_cmd_last)
            begin
                s_d.state = (dest == ST_FWD && s_d.query) ? ST_RSP : ST_IDLE;
            end
            else
            begin
                s_d.state = dest;
            end
        end
        if (take_rsp)
        begin
            s_d.out_valid = 1'b1;
            s_d.out_byte = i_rsp_byte;
            s_d.out_last = i_rsp_last;
            if (i_rsp_last)
            begin
                s_d.state = ST_IDLE;
            end
        end
        // Set wins over a clear that lands in the same cycle.
        if (i_stb_read)
        begin
            s_d.slave_flag = 1'b0;
        end
        if (i_slave_srv && s_q.is_master)
        begin
            s_d.slave_flag = 1'b1;
        end
        stb_n[STB_FAIL] = i_fail_sum;
        stb_n[STB_SLAVE] = s_d.slave_flag;
        stb_n[STB_QUES] = i_ques_sum;
        stb_n[STB_MAV] = i_local_mav && s_q.is_master;
        stb_n[STB_ESB] = i_esb_sum;
        stb_n[STB_OPER] = i_oper_sum;
        // A slave folds pending output into its request so the master notices it.
        stb_n[STB_RQS] = (|stb_n) || i_need_service || i_local_mav;
        s_d.stb = stb_n;
        s_d.srq = stb_n[STB_RQS] && s_q.is_master;
        s_d.master_srv = stb_n[STB_RQS] && !s_q.is_master;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            s_q <= '{state: ST_IDLE, stb: STB_RESET, default: '0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_local_valid = s_q.local_valid;
    assign o_local_byte = s_q.local_byte;
    assign o_local_last = s_q.local_last;
    assign o_local_reset = s_q.local_reset;
    assign o_mbus_valid = s_q.mbus_valid;
    assign o_mbus_byte = s_q.mbus_byte;
    assign o_mbus_last = s_q.mbus_last;
    assign o_mbus_row = s_q.fwd_row;
    assign o_out_valid = s_q.out_valid;
    assign o_out_byte = s_q.out_byte;
    assign o_out_last = s_q.out_last;
    assign o_srq = s_q.srq;
    assign o_master_srv = s_q.master_srv;
    assign o_status_byte = s_q.stb;
    assign o_cmd_error = s_q.cmd_error;
    assign o_is_master = s_q.is_master;
    assign o_bus_addr = s_q.bus_addr;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence seq_relay_start;
        take_cmd && i_cmd_first && accept_ok && (s_q.state == ST_IDLE)
            && (i_cmd_kind == KIND_RELAY) && !i_cmd_block_data;
    endsequence

    sequence seq_block_relay;
        take_cmd && i_cmd_first && accept_ok && (s_q.state == ST_IDLE)
            && (i_cmd_kind == KIND_RELAY_QUERY || i_cmd_kind == KIND_RELAY)
            && i_cmd_block_data;
    endsequence

    AST_RELAY_FORWARDS: assert property (seq_relay_start |=> o_mbus_valid
        && (o_mbus_byte == $past(i_cmd_byte)) && !o_local_valid)
        else $error("Relay byte not forwarded unchanged.");
    AST_RELAY_ROW: assert property (seq_relay_start |=> (o_mbus_row > s_q.own_row)
        || (o_mbus_row == P_DEFAULT_SLAVE_ROW))
        else $error("Relay target row not above own row.");
    AST_SLAVE_IGNORES_HOST: assert property (s_q.straps_taken && !s_q.is_master
        && take_cmd && !i_cmd_via_master && (s_q.state == ST_IDLE)
        |=> !o_local_valid && !o_mbus_valid)
        else $error("Slave acted on a host command.");
    AST_QUERY_WAITS: assert property (take_cmd && i_cmd_last && (s_q.state == ST_FWD)
        && s_q.query |=> (s_q.state == ST_RSP))
        else $error("Relayed query did not wait for answer.");
    AST_PATTERN_AUTO: assert property (take_cmd && i_cmd_first && accept_ok
        && (s_q.state == ST_IDLE) && (i_cmd_kind == KIND_PATTERN_NODE)
        && i_pattern_slave_mode |=> o_mbus_valid)
        else $error("Pattern node command not forwarded.");
    AST_RESET_LOCAL: assert property (o_local_reset |-> $past(take_cmd)
        && ($past(i_cmd_kind) == KIND_RESET) && o_local_valid)
        else $error("Local reset without a direct reset command.");
    AST_SLAVE_NO_SRQ: assert property (!s_q.is_master |-> ##1 !o_srq)
        else $error("Slave raised a host service request.");
    AST_SLAVE_FLAG: assert property (s_q.is_master && i_slave_srv
        |=> o_status_byte[STB_SLAVE] && o_status_byte[STB_RQS])
        else $error("Slave service not shown in status byte.");
    AST_SLAVE_NO_MAV: assert property (!s_q.is_master |=> !o_status_byte[STB_MAV])
        else $error("Slave set message available.");
    AST_SLAVE_REQUEST: assert property (!s_q.is_master && i_local_mav
        |=> o_master_srv && o_status_byte[STB_RQS])
        else $error("Slave did not request service from master.");
    AST_ANSWER_QUEUED: assert property (take_rsp |=> o_out_valid
        && (o_out_byte == $past(i_rsp_byte)))
        else $error("Relayed answer not queued.");
    AST_BLOCK_REJECT: assert property (seq_block_relay |=> o_cmd_error
        && !o_mbus_valid ##1 !o_cmd_error)
        else $error("Block data relay not rejected.");

endmodule // mscr_relay
